// File: src/abw_pkg.sv
package abw_pkg;

  // ----------------------------------------------------------------
  // Counter clock divide ratios (system clock cycles per count tick)
  // ----------------------------------------------------------------
  localparam int unsigned PRESCALE_W = 9;
  localparam logic [PRESCALE_W-1:0] DIV_FAST_LAST = 9'h01f; // /32
  localparam logic [PRESCALE_W-1:0] DIV_MID_LAST  = 9'h07f; // /128
  localparam logic [PRESCALE_W-1:0] DIV_SLOW_LAST = 9'h1ff; // /512
  localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 9'h000;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ONE  = 9'h001;

  // ----------------------------------------------------------------
  // Divisor counter
  // ----------------------------------------------------------------
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
  localparam logic [DIV_W-1:0] DIV_START = 16'h0001;
  localparam logic [DIV_W-1:0] DIV_ONE   = 16'h0001;
  localparam logic [DIV_W-1:0] DIV_MAX   = 16'hffff;

  // ----------------------------------------------------------------
  // Sync character edge count
  // ----------------------------------------------------------------
  localparam int unsigned EDGE_W = 3;
  localparam logic [EDGE_W-1:0] EDGE_FIRST = 3'h1;
  localparam logic [EDGE_W-1:0] EDGE_LAST  = 3'h5;
  localparam logic [EDGE_W-1:0] EDGE_ONE   = 3'h1;
  localparam logic [EDGE_W-1:0] EDGE_ZERO  = 3'h0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ABW_IDLE       = 3'b000,
    ABW_WAKE_ARMED = 3'b001,
    ABW_WAKE_BREAK = 3'b010,
    ABW_CAL_START  = 3'b011,
    ABW_CAL_FIRST  = 3'b100,
    ABW_CAL_COUNT  = 3'b101
  } abw_state_e;

endpackage

// File: src/abw_autobaud_wake.sv
`timescale 1ns/1ps
// How it works
// - Autobaud enable starts calibration; receiver held idle until done.
// - Divisor counter starts on first receive rising edge after start bit.
// - Measures 55h sync; ends at fifth rising edge, after eight bits.
// - At fifth edge: keep count, clear autobaud enable, set receive flag.
// - Reading receive data clears receive flag; software discards that data.
// - Both divisor halves form one 16-bit counter during calibration.
// - Count clock: 1,1 osc/32; 1,0 or 0,1 osc/128; 0,0 osc/512.
// - Counter runs at one eighth of normal prescaler base rate.
// - Counter starts at one; software subtracts one afterwards.
// - Wake plus autobaud enabled: calibrate on byte after the break.
// - Counter overflow sets overflow flag; counting continues to fifth edge.
// - Overflow flag clearable; stays set while autobaud enable still set.
// - Wake enable disables reception; falling receive edge is wake event.
// - Wake on break works only in asynchronous mode.
// - Wake event sets receive flag; reading receive data clears it.
// - Rising edge ending break clears wake enable; then idle.
// - In sleep, divisor generator stops and no reception occurs.
// - Nonzero character: low time to first rise counts as wake.

module abw_autobaud_wake (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // Serial line
  input  wire logic                       rx_in,
  // Software control strobes and divisor write data
  input  wire logic                       autobaud_enable_set,
  input  wire logic                       autobaud_enable_clr,
  input  wire logic                       overflow_clr,
  input  wire logic                       wake_enable_set,
  input  wire logic                       wake_enable_clr,
  input  wire logic                       receive_data_read,
  input  wire logic                       divisor_write,
  input  wire logic [abw_pkg::DIV_W-1:0]  divisor_wdata,
  // Configuration levels
  input  wire logic                       wide_divisor_select,
  input  wire logic                       high_speed_select,
  input  wire logic                       async_mode,
  input  wire logic                       sleep_mode,
  // Status
  output logic                            autobaud_enable,
  output logic                            autobaud_overflow_flag,
  output logic                            wake_on_break_enable,
  output logic                            receive_irq_flag,
  output logic [7:0]                      divisor_high,
  output logic [7:0]                      divisor_low,
  output logic                            receiver_idle_status,
  output logic                            receiver_hold
);

  import abw_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  abw_state_e                state;
  abw_state_e                next_state;
  logic                      rx_prev;
  logic                      rx_rise;
  logic                      rx_fall;
  logic [PRESCALE_W-1:0]     prescale;
  logic [PRESCALE_W-1:0]     next_prescale;
  logic [PRESCALE_W-1:0]     prescale_last;
  logic                      tick;
  logic                      next_tick;
  logic [DIV_W-1:0]          divisor;
  logic [DIV_W-1:0]          next_divisor;
  logic [EDGE_W-1:0]         edges;
  logic [EDGE_W-1:0]         next_edges;
  logic                      next_autobaud_enable;
  logic                      next_autobaud_overflow_flag;
  logic                      next_wake_on_break_enable;
  logic                      next_receive_irq_flag;
  logic                      next_receiver_idle_status;
  logic                      next_receiver_hold;
  logic                      cal_done;
  logic                      cal_overflow;
  logic                      wake_event;
  logic                      wake_end;
  logic                      abd_live;
  logic                      wake_live;

  // ----------------------------------------------------------------
  // Receive line edges
  // ----------------------------------------------------------------
  // Line is taken as synchronous, so a single history flop suffices.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_in;
    end
  end

  assign rx_rise = rx_in & ~rx_prev;
  assign rx_fall = ~rx_in & rx_prev;

  // ----------------------------------------------------------------
  // Count clock prescaler
  // ----------------------------------------------------------------
  // Ratios already include the divide by eight against the base clock.
  always_comb begin
    if (wide_divisor_select && high_speed_select) begin
      prescale_last = DIV_FAST_LAST;
    end else if (wide_divisor_select || high_speed_select) begin
      prescale_last = DIV_MID_LAST;
    end else begin
      prescale_last = DIV_SLOW_LAST;
    end
  end

  always_comb begin
    next_prescale = prescale;
    next_tick     = 1'b0;
    if (sleep_mode) begin
      next_prescale = PRESCALE_ZERO;
    end else if (prescale >= prescale_last) begin
      next_prescale = PRESCALE_ZERO;
      next_tick     = 1'b1;
    end else begin
      next_prescale = prescale + PRESCALE_ONE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= PRESCALE_ZERO;
      tick     <= 1'b0;
    end else begin
      prescale <= next_prescale;
      tick     <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Wake handling takes precedence, so calibration waits for the byte
  // that follows the break.
  assign wake_live = wake_on_break_enable && async_mode;
  assign abd_live  = autobaud_enable && !autobaud_enable_clr;

  always_comb begin
    next_state = state;
    case (state)
      ABW_IDLE: begin
        if (wake_live) begin
          next_state = ABW_WAKE_ARMED;
        end else if (abd_live) begin
          next_state = ABW_CAL_START;
        end
      end
      ABW_WAKE_ARMED: begin
        if (!wake_live) begin
          next_state = ABW_IDLE;
        end else if (rx_fall) begin
          next_state = ABW_WAKE_BREAK;
        end
      end
      ABW_WAKE_BREAK: begin
        if (!wake_live || rx_rise) begin
          next_state = ABW_IDLE;
        end
      end
      ABW_CAL_START: begin
        if (!abd_live) begin
          next_state = ABW_IDLE;
        end else if (rx_fall && !sleep_mode) begin
          next_state = ABW_CAL_FIRST;
        end
      end
      ABW_CAL_FIRST: begin
        if (!abd_live) begin
          next_state = ABW_IDLE;
        end else if (rx_rise && !sleep_mode) begin
          next_state = ABW_CAL_COUNT;
        end
      end
      ABW_CAL_COUNT: begin
        if (!abd_live || cal_done) begin
          next_state = ABW_IDLE;
        end
      end
      default: begin
        next_state = ABW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ABW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Sequence events
  // ----------------------------------------------------------------
  assign wake_event = (state == ABW_WAKE_ARMED) && wake_live && rx_fall;
  assign wake_end   = (state == ABW_WAKE_BREAK) && wake_live && rx_rise;
  assign cal_done   = (state == ABW_CAL_COUNT) && abd_live && rx_rise
                      && !sleep_mode && (edges == EDGE_LAST - EDGE_ONE);
  assign cal_overflow = (state == ABW_CAL_COUNT) && tick
                        && (divisor == DIV_MAX);

  // ----------------------------------------------------------------
  // Divisor counter and edge count
  // ----------------------------------------------------------------
  // Software may load the divisor, but a running calibration owns it.
  always_comb begin
    next_divisor = divisor;
    next_edges   = edges;
    if (state == ABW_CAL_FIRST && rx_rise && abd_live && !sleep_mode) begin
      next_divisor = DIV_START;
      next_edges   = EDGE_FIRST;
    end else if (state == ABW_CAL_COUNT) begin
      if (tick) begin
        next_divisor = divisor + DIV_ONE;
      end
      if (rx_rise && !sleep_mode) begin
        next_edges = edges + EDGE_ONE;
      end
    end else if (divisor_write) begin
      next_divisor = divisor_wdata;
      next_edges   = EDGE_ZERO;
    end else begin
      next_edges = EDGE_ZERO;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      divisor <= DIV_RESET;
      edges   <= EDGE_ZERO;
    end else begin
      divisor <= next_divisor;
      edges   <= next_edges;
    end
  end

  // ----------------------------------------------------------------
  // Calibration flags
  // ----------------------------------------------------------------
  // Hardware sets win over software clears in the same cycle.
  always_comb begin
    next_autobaud_enable = autobaud_enable;
    if (autobaud_enable_set) begin
      next_autobaud_enable = 1'b1;
    end else if (autobaud_enable_clr || cal_done) begin
      next_autobaud_enable = 1'b0;
    end

    // A clear while enable stands is lost; an abort drops enable first
    next_autobaud_overflow_flag = autobaud_overflow_flag;
    if (cal_overflow) begin
      next_autobaud_overflow_flag = 1'b1;
    end else if (overflow_clr && !autobaud_enable) begin
      next_autobaud_overflow_flag = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      autobaud_enable        <= 1'b0;
      autobaud_overflow_flag <= 1'b0;
    end else begin
      autobaud_enable        <= next_autobaud_enable;
      autobaud_overflow_flag <= next_autobaud_overflow_flag;
    end
  end

  // ----------------------------------------------------------------
  // Wake and receive flags
  // ----------------------------------------------------------------
  // Break end wins over a same-cycle set; software must set it again.
  always_comb begin
    next_wake_on_break_enable = wake_on_break_enable;
    if (wake_end) begin
      next_wake_on_break_enable = 1'b0;
    end else if (wake_enable_set) begin
      next_wake_on_break_enable = 1'b1;
    end else if (wake_enable_clr) begin
      next_wake_on_break_enable = 1'b0;
    end

    next_receive_irq_flag = receive_irq_flag;
    if (cal_done || wake_event) begin
      next_receive_irq_flag = 1'b1;
    end else if (receive_data_read) begin
      next_receive_irq_flag = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wake_on_break_enable <= 1'b0;
      receive_irq_flag     <= 1'b0;
    end else begin
      wake_on_break_enable <= next_wake_on_break_enable;
      receive_irq_flag     <= next_receive_irq_flag;
    end
  end

  // ----------------------------------------------------------------
  // Receiver status
  // ----------------------------------------------------------------
  // Normal receiver is parked whenever either feature owns the line;
  // a set wake bit parks it in any mode, so nothing is half-received.
  always_comb begin
    next_receiver_hold = next_autobaud_enable
                         || next_wake_on_break_enable
                         || sleep_mode;
    next_receiver_idle_status = (next_state == ABW_IDLE)
                                || (next_state == ABW_WAKE_ARMED)
                                || (next_state == ABW_CAL_START);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      receiver_hold        <= 1'b0;
      receiver_idle_status <= 1'b1;
    end else begin
      receiver_hold        <= next_receiver_hold;
      receiver_idle_status <= next_receiver_idle_status;
    end
  end

  // ----------------------------------------------------------------
  // Divisor outputs
  // ----------------------------------------------------------------
  // Both halves always come from the one 16-bit register.
  assign divisor_high = divisor[DIV_W-1:8];
  assign divisor_low  = divisor[7:0];

endmodule // abw_autobaud_wake

// File: verification/abw_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Checker for the calibration and wake sequencer
// ------------------------------------------------------------
module abw_properties (
  // Clock and reset
  input wire logic       clock,
  input wire logic       reset_n,
  // Inputs that cause flag and divisor changes
  input wire logic       rx_in,
  input wire logic       autobaud_enable_clr,
  input wire logic       overflow_clr,
  input wire logic       receive_data_read,
  input wire logic       divisor_write,
  input wire logic       async_mode,
  // Status
  input wire logic       autobaud_enable,
  input wire logic       autobaud_overflow_flag,
  input wire logic       wake_on_break_enable,
  input wire logic       receive_irq_flag,
  input wire logic [7:0] divisor_high,
  input wire logic [7:0] divisor_low,
  input wire logic       receiver_hold
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Armed takes one edge after the enable shows, so two cycles are asked
  sequence s_armed_fall;
    (wake_on_break_enable && async_mode)[*2] ##1
      (wake_on_break_enable && async_mode && $fell(rx_in));
  endsequence
  sequence s_break_end;
    s_armed_fall ##1 (!rx_in)[*8] ##[1:1000] $rose(rx_in);
  endsequence
  property p_cal_hold;
    autobaud_enable |-> receiver_hold;
  endproperty
  property p_wake_hold;
    wake_on_break_enable |-> receiver_hold;
  endproperty
  property p_cal_done;
    $fell(autobaud_enable) && !$past(autobaud_enable_clr) |-> receive_irq_flag;
  endproperty
  property p_div_keep;
    !autobaud_enable && !divisor_write
      |=> $stable({divisor_high, divisor_low});
  endproperty
  property p_ovf_keep;
    autobaud_enable && autobaud_overflow_flag |=> autobaud_overflow_flag;
  endproperty
  property p_ovf_clr;
    !autobaud_enable && overflow_clr |=> !autobaud_overflow_flag;
  endproperty
  property p_wake_irq;
    s_armed_fall |=> receive_irq_flag;
  endproperty
  property p_wake_end;
    s_break_end |=> !wake_on_break_enable;
  endproperty
  property p_sync_only;
    !async_mode && !autobaud_enable && !receive_irq_flag |=> !receive_irq_flag;
  endproperty
  property p_read_clr;
    receive_data_read && !autobaud_enable && !wake_on_break_enable
      |=> !receive_irq_flag;
  endproperty
  a_cal_hold: assert property (p_cal_hold)
    else $error("receiver not held during calibration");
  a_wake_hold: assert property (p_wake_hold)
    else $error("receiver not held while wake enabled");
  a_cal_done: assert property (p_cal_done)
    else $error("calibration ended without receive flag");
  a_div_keep: assert property (p_div_keep)
    else $error("divisor moved outside calibration");
  a_ovf_keep: assert property (p_ovf_keep)
    else $error("overflow flag dropped while enabled");
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("overflow flag not cleared");
  a_wake_irq: assert property (p_wake_irq)
    else $error("wake fall did not raise receive flag");
  a_wake_end: assert property (p_wake_end)
    else $error("wake enable kept after break end");
  a_sync_only: assert property (p_sync_only)
    else $error("receive flag raised outside async mode");
  a_read_clr: assert property (p_read_clr)
    else $error("read did not clear receive flag");
endmodule // abw_properties

// File: verification/abw_remote_tx.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Remote transmitter: sync characters and breaks
// ------------------------------------------------------------
module abw_remote_tx (
  // Clock
  input wire logic clock,
  // Serial line, idle high
  output logic     rx_line
);
  initial rx_line = 1'b1;
  // Bits go out LSB first; line returns high, then a two-bit gap so
  // the receiver has time to settle before anything follows
  task automatic send(input logic [15:0] bits, input int nbits,
                      input int bit_clk);
    @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      rx_line <= bits[i];
      repeat (bit_clk) @(posedge clock);
    end
    rx_line <= 1'b1;
    repeat (2 * bit_clk) @(posedge clock);
  endtask
endmodule // abw_remote_tx

// File: verification/abw_autobaud_wake_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module abw_autobaud_wake_tb;
  import abw_pkg::*;
  typedef struct packed {
    logic        wide;
    logic        high;
    int          bit_clk;
    logic [15:0] count;
  } abw_row_s;
  // Count is one plus eight bit times in ticks; the window holds whole
  // tick periods, so the free-running prescaler phase cannot shift it
  abw_row_s rows [4] = '{'{1'b1, 1'b1, 64, 16'h0011},
    '{1'b1, 1'b0, 128, 16'h0009}, '{1'b0, 1'b1, 256, 16'h0011},
    '{1'b0, 1'b0, 512, 16'h0009}};
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [6:0]  st = 7'h00;
  logic        wide = 1'b1;
  logic        high = 1'b1;
  logic        async_mode = 1'b1;
  logic        sleep_mode = 1'b0;
  logic        rx_in;
  logic        abe, ovf, wen, irq, idle, hold;
  logic [7:0]  dh, dl;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Strobe bit positions in st
  localparam logic [6:0] AB_SET = 7'h01, AB_CLR = 7'h02, OVF_CLR = 7'h04;
  localparam logic [6:0] WK_SET = 7'h08, WK_CLR = 7'h10, RD = 7'h20;
  localparam logic [6:0] DWR = 7'h40;
  always #5 clock = ~clock;
  abw_remote_tx tx_u (.clock(clock), .rx_line(rx_in));
  abw_autobaud_wake dut_u (.clock(clock), .reset_n(reset_n), .rx_in(rx_in),
    .autobaud_enable_set(st[0]), .autobaud_enable_clr(st[1]),
    .overflow_clr(st[2]), .wake_enable_set(st[3]), .wake_enable_clr(st[4]),
    .receive_data_read(st[5]), .divisor_write(st[6]),
    .divisor_wdata(16'h1234), .wide_divisor_select(wide),
    .high_speed_select(high), .async_mode(async_mode),
    .sleep_mode(sleep_mode), .autobaud_enable(abe),
    .autobaud_overflow_flag(ovf), .wake_on_break_enable(wen),
    .receive_irq_flag(irq), .divisor_high(dh), .divisor_low(dl),
    .receiver_idle_status(idle), .receiver_hold(hold));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_div(input logic [15:0] e);
    chk("divisor", e, {dh, dl});
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge clock) st <= m;
    @(posedge clock) st <= 7'h00;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_cal_end;
    for (int n = 0; n < 20000 && abe !== 1'b0; n++) @(posedge clock);
    step(1);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    step(16);
    chk("reset flags", 16'h0002, 16'({abe, ovf, wen, irq, idle, hold}));
    chk("reset divisor", 16'h0000, {dh, dl});
    $display("test reset done");
    @(posedge clock) reset_n <= 1'b1;
    step(2);
    for (int r = 0; r < 4; r++) begin
      @(posedge clock) {wide, high} <= {rows[r].wide, rows[r].high};
      pulse(AB_SET);
      step(1);
      chk("hold", 16'h0001, 16'(hold));
      tx_u.send(16'h02aa, 10, rows[r].bit_clk);
      wait_cal_end();
      chk("done flags", 16'h0001, 16'({abe, irq}));
      chk_div(rows[r].count);
      if (!rows[r].wide) chk("high byte", 16'h0000, 16'(dh));
      pulse(RD);
      step(1);
      chk("irq read", 16'h0000, 16'(irq));
      $display("test calibration row %0d done", r);
    end
    @(posedge clock) {wide, high} <= 2'b11;
    pulse(DWR);
    step(1);
    chk("written divisor", 16'h1234, {dh, dl});
    chk("idle before wake", 16'h0001, 16'(idle));
    pulse(WK_SET);
    step(3);
    chk("wake armed", 16'h0003, 16'({wen, hold}));
    tx_u.send(16'h0000, 13, 64);
    chk("wake end", 16'h0001, 16'({wen, irq}));
    pulse(RD);
    $display("test wake on break done");
    pulse(AB_SET | WK_SET);
    step(3);
    tx_u.send(16'h0000, 13, 64);
    chk("cal waits", 16'h0005, 16'({abe, wen, irq}));
    pulse(RD);
    tx_u.send(16'h02aa, 10, 64);
    wait_cal_end();
    chk("wake cal", 16'h0001, 16'({abe, irq}));
    chk_div(16'h0011);
    pulse(RD);
    $display("test wake then calibration done");
    @(posedge clock) async_mode <= 1'b0;
    pulse(WK_SET);
    step(3);
    tx_u.send(16'h0000, 13, 64);
    chk("sync mode irq", 16'h0000, 16'(irq));
    pulse(WK_CLR);
    @(posedge clock) {async_mode, sleep_mode} <= 2'b11;
    pulse(AB_SET);
    tx_u.send(16'h02aa, 10, 64);
    step(1);
    chk("sleep cal", 16'h0002, 16'({abe, irq}));
    pulse(AB_CLR);
    pulse(OVF_CLR);
    step(1);
    chk("abort", 16'h0000, 16'({abe, ovf}));
    $display("test sync mode, sleep and abort done");
    print_verdict();
  end
endmodule // abw_autobaud_wake_tb
bind abw_autobaud_wake abw_properties chk_u (.clock, .reset_n, .rx_in,
  .autobaud_enable_clr, .overflow_clr, .receive_data_read, .divisor_write,
  .async_mode, .autobaud_enable, .autobaud_overflow_flag,
  .wake_on_break_enable, .receive_irq_flag, .divisor_high, .divisor_low,
  .receiver_hold);
